/* core/lsl_map.svh */
// Purpose: constants of the segment shift latch block.
// Assumes: system clock of 125 MHz.
// Notes:   shared by the package, the backplane generator and the shift latch.
//
// Summary of operation
// (R01) 31-bit shift register, one bit per segment
// (R02) latches hold segments until next transfer strobe
// (R03) strobe high passes shift data, low holds
// (R04) strobe tied high: outputs follow every shift
// (R05) host shifts frame under 0.1 s, then stops
// (R06) last shift bit appears on cascade output
// (R07) segment bit one drives inverse of backplane
`ifndef LSL_MAP_SVH
`define LSL_MAP_SVH

// segment count and top bit of the chain
`define LSL_SEG_W 31
`define LSL_SEG_TOP 30

// crossing ring of single bits, gray-coded pointers
`define LSL_PTR_W 3
`define LSL_RING_N 8

// backplane square wave, derived from the system rate
`define LSL_CLK_HZ 125000000
`define LSL_BP_FREQ_HZ 32
`define LSL_BP_HALF_CYC (`LSL_CLK_HZ / (2 * `LSL_BP_FREQ_HZ))
`define LSL_BP_CNT_W 24

// fill count at which the cascade output is valid
`define LSL_FILL_W 5
`define LSL_FILL_FULL 5'h1F

`endif

/* core/lsl_pkg.sv */
// Purpose: types and pointer helpers of the shift latch block.
// Assumes: lsl_map.svh is on the include path.
// Notes:   gray helpers serve the bit ring crossing.
`default_nettype none
`include "lsl_map.svh"

package lsl_pkg;

  typedef logic [`LSL_SEG_W-1:0] lsl_seg_t;
  typedef logic [`LSL_PTR_W-1:0] lsl_ptr_t;
  typedef logic [`LSL_BP_CNT_W-1:0] lsl_bp_cnt_t;
  typedef logic [`LSL_FILL_W-1:0] lsl_fill_t;

  // binary to gray for the write pointer
  function automatic lsl_ptr_t lsl_bin2gray(input lsl_ptr_t b);
    return b ^ (b >> 1);
  endfunction : lsl_bin2gray

  // gray back to binary on the reading side
  function automatic lsl_ptr_t lsl_gray2bin(input lsl_ptr_t g);
    lsl_ptr_t b;
    b = g;
    for (int i = `LSL_PTR_W - 2; i >= 0; i--) begin
      b[i] = b[i+1] ^ g[i];
    end
    return b;
  endfunction : lsl_gray2bin

endpackage : lsl_pkg

`default_nettype wire

/* core/lsl_sync.sv */
// Purpose: two-flop synchroniser for levels and gray words.
// Assumes: each bit changes alone or is a plain level.
// Notes:   first stage feeds only the second stage.
`default_nettype none

module lsl_sync #(
  parameter int W = 1
) (
  // clock of the receiving domain
  input  wire logic         i_clk,
  // asynchronous input and synchronised output
  input  wire logic [W-1:0] i_d,
  output logic      [W-1:0] o_q
);

  logic [W-1:0] meta_q;
  logic [W-1:0] safe_q;

  // two stages, no reset, no logic between them
  always_ff @(posedge i_clk) begin
    meta_q <= i_d;
    safe_q <= meta_q;
  end

  assign o_q = safe_q;

endmodule : lsl_sync

`default_nettype wire

/* core/lsl_bp_gen.sv */
// Purpose: backplane square wave from the system clock.
// Assumes: half period of at least two cycles.
// Notes:   the wave starts low after reset.
`default_nettype none
`include "lsl_map.svh"

module lsl_bp_gen
  import lsl_pkg::*;
#(
  parameter int unsigned HALF_CYC = `LSL_BP_HALF_CYC
) (
  // system clock and reset
  input  wire logic i_clk,
  input  wire logic i_rst,
  // backplane level
  output logic      o_bp
);

  localparam lsl_bp_cnt_t LIM = lsl_bp_cnt_t'(HALF_CYC - 1);

  lsl_bp_cnt_t cnt_q, cnt_d;
  logic        bp_q, bp_d;

  // count a half period, then flip the wave
  always_comb begin
    cnt_d = lsl_bp_cnt_t'(cnt_q + 1'b1);
    bp_d  = bp_q;
    if (cnt_q == LIM) begin
      cnt_d = '0;
      bp_d  = ~bp_q;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      cnt_q <= '0;
      bp_q  <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      bp_q  <= bp_d;
    end
  end

  assign o_bp = bp_q;

endmodule : lsl_bp_gen

`default_nettype wire

/* core/lsl_shift_latch.sv */
// Purpose: serial-in segment shift register with display latches.
// Assumes: shift clock from the host, data valid at its rise.
// Notes:   load strobe is a level; tie high for two-wire use.
//          the strobe is resampled, so it acts a few cycles late.
//          link reset lags the system reset by two host clocks.
`default_nettype none
`include "lsl_map.svh"

module lsl_shift_latch
  import lsl_pkg::*;
#(
  parameter int unsigned BP_HALF_CYC = `LSL_BP_HALF_CYC
) (
  // system clock and reset
  input  wire logic           i_clk_sys,
  input  wire logic           i_sys_rst,
  // serial link from the host
  input  wire logic           i_shift_clk,
  input  wire logic           i_ser_data,
  input  wire logic           i_load,
  // cascade to the next driver
  output logic                o_cascade_out,
  // display drive
  output logic                o_backplane_drive,
  output lsl_pkg::lsl_seg_t   o_seg
);

  // link domain: host shift register and bit log

  logic      lnk_rst;
  lsl_seg_t  lnk_shift_q, lnk_shift_d;
  lsl_ptr_t  lnk_wptr_q, lnk_wptr_d;
  lsl_ptr_t  lnk_wgray_q, lnk_wgray_d;
  lsl_fill_t lnk_fill_q, lnk_fill_d;
  logic      ring_q [`LSL_RING_N];

  // reset carried into the shift clock domain
  lsl_sync #(
    .W (1)
  ) u_lnk_rst (
    .i_clk (i_shift_clk),
    .i_d   (i_sys_rst),
    .o_q   (lnk_rst)
  );

  // shift one bit per host clock, log it in the ring
  always_comb begin
    lnk_shift_d = {lnk_shift_q[`LSL_SEG_TOP-1:0], i_ser_data}; // R01
    lnk_wptr_d  = lsl_ptr_t'(lnk_wptr_q + 1'b1);
    lnk_wgray_d = lsl_bin2gray(lnk_wptr_d);
    lnk_fill_d  = lnk_fill_q;
    if (lnk_fill_q != `LSL_FILL_FULL) begin
      lnk_fill_d = lsl_fill_t'(lnk_fill_q + 1'b1);
    end
  end

  always_ff @(posedge i_shift_clk) begin
    if (lnk_rst) begin
      lnk_shift_q <= '0;
      lnk_wptr_q  <= '0;
      lnk_wgray_q <= '0;
      lnk_fill_q  <= '0;
    end else begin
      lnk_shift_q <= lnk_shift_d;
      lnk_wptr_q  <= lnk_wptr_d;
      lnk_wgray_q <= lnk_wgray_d;
      lnk_fill_q  <= lnk_fill_d;
    end
  end

  // ring entries need no reset; pointers guard them
  always_ff @(posedge i_shift_clk) begin
    ring_q[lnk_wptr_q] <= i_ser_data;
  end

  // chained bit leaves from the top of the register
  assign o_cascade_out = lnk_shift_q[`LSL_SEG_TOP]; // R06

  // system domain: mirror, latch and drive

  lsl_ptr_t wgray_s;
  lsl_ptr_t wbin_s;
  logic     load_s;
  lsl_ptr_t rptr_q, rptr_d;
  lsl_seg_t mirror_q, mirror_d;
  lsl_seg_t latch_q, latch_d;
  lsl_seg_t seg_q, seg_d;
  logic     bp_raw;
  logic     bp_out_q, bp_out_d;

  // gray write pointer into the system clock
  lsl_sync #(
    .W (`LSL_PTR_W)
  ) u_wptr_sync (
    .i_clk (i_clk_sys),
    .i_d   (lnk_wgray_q),
    .o_q   (wgray_s)
  );

  // load strobe is a pin level, two flops first
  lsl_sync #(
    .W (1)
  ) u_load_sync (
    .i_clk (i_clk_sys),
    .i_d   (i_load),
    .o_q   (load_s)
  );

  // backplane wave source
  lsl_bp_gen #(
    .HALF_CYC (BP_HALF_CYC)
  ) u_bp_gen (
    .i_clk (i_clk_sys),
    .i_rst (i_sys_rst),
    .o_bp  (bp_raw)
  );

  assign wbin_s = lsl_gray2bin(wgray_s);

  // replay logged bits into a mirror of the register
  always_comb begin
    rptr_d   = rptr_q;
    mirror_d = mirror_q;
    if (rptr_q != wbin_s) begin
      mirror_d = {mirror_q[`LSL_SEG_TOP-1:0], ring_q[rptr_q]}; // R01
      rptr_d   = lsl_ptr_t'(rptr_q + 1'b1);
    end
  end

  // latch transparent while strobe high, else held
  always_comb begin
    latch_d = latch_q; // R02
    if (load_s) begin
      latch_d = mirror_q; // R03 R04
    end
  end

  // segment in phase with backplane for 0, inverse for 1
  always_comb begin
    seg_d    = latch_q ^ {`LSL_SEG_W{bp_raw}}; // R07
    bp_out_d = bp_raw;
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      rptr_q   <= '0;
      mirror_q <= '0;
      latch_q  <= '0;
      seg_q    <= '0;
      bp_out_q <= 1'b0;
    end else begin
      rptr_q   <= rptr_d;
      mirror_q <= mirror_d;
      latch_q  <= latch_d;
      seg_q    <= seg_d;
      bp_out_q <= bp_out_d;
    end
  end

  assign o_seg             = seg_q;
  assign o_backplane_drive = bp_out_q;

  // checks on the host clock

  // one new bit enters at the bottom each host clock
  sequence lnk_run_s;
    !lnk_rst ##1 !lnk_rst;
  endsequence

  property shift_step_p;
    @(posedge i_shift_clk) disable iff (lnk_rst)
      lnk_run_s |->
        lnk_shift_q == {$past(lnk_shift_q[`LSL_SEG_TOP-1:0]),
                        $past(i_ser_data)};
  endproperty

  shift_move_a: assert property (shift_step_p) // R01
    else $error("shift register did not take the data bit");

  // a bit leaves on the cascade 31 host clocks later
  cascade_out_a: assert property ( // R06
    @(posedge i_shift_clk) disable iff (lnk_rst)
      (lnk_fill_q == `LSL_FILL_FULL) && $past(lnk_fill_q == 
        `LSL_FILL_FULL) |->
        o_cascade_out == $past(i_ser_data, 31)
  ) else $error("cascade output is not the bit from 31 shifts");

  // reset empties the chain, cascade starts low
  cascade_rst_a: assert property ( // R06
    @(posedge i_shift_clk)
      lnk_rst |=> !o_cascade_out
  ) else $error("cascade output not low after link reset");

  // nothing reaches the cascade before the chain fills
  cascade_fill_a: assert property ( // R06
    @(posedge i_shift_clk) disable iff (lnk_rst)
      (lnk_fill_q != `LSL_FILL_FULL) |-> !o_cascade_out
  ) else $error("cascade output rose before the chain filled");

  // fill count saturates once the chain is full
  fill_sat_a: assert property ( // R06
    @(posedge i_shift_clk) disable iff (lnk_rst)
      (lnk_fill_q == `LSL_FILL_FULL) |=> (lnk_fill_q == `LSL_FILL_FULL)
  ) else $error("fill count left the full value");

  // write pointer steps by one for every host clock
  wptr_step_a: assert property ( // R01
    @(posedge i_shift_clk) disable iff (lnk_rst)
      lnk_run_s |-> lnk_wptr_q == lsl_ptr_t'($past(lnk_wptr_q) + 1'b1)
  ) else $error("write pointer did not step by one");

  // gray pointer changes in exactly one bit per shift
  gray_one_a: assert property ( // R01
    @(posedge i_shift_clk) disable iff (lnk_rst)
      lnk_run_s |-> $countones(lnk_wgray_q ^ $past(lnk_wgray_q)) == 1
  ) else $error("gray write pointer moved in more than one bit");

  // every taken bit is logged at the old pointer
  ring_log_a: assert property ( // R01
    @(posedge i_shift_clk) disable iff (lnk_rst)
      lnk_run_s |-> ring_q[$past(lnk_wptr_q)] == $past(i_ser_data)
  ) else $error("crossing ring did not log the data bit");

  // checks on the system clock

  // pending bits drain quickly, ring cannot overrun
  ring_drain_a: assert property ( // R01
    @(posedge i_clk_sys) disable iff (i_sys_rst)
      (rptr_q != wbin_s) |-> ##[1:8] (rptr_q == wbin_s)
  ) else $error("crossing ring did not drain in time");

  // held contents stay put while the strobe is low
  latch_hold_a: assert property ( // R02
    @(posedge i_clk_sys) disable iff (i_sys_rst)
      !load_s |=> $stable(latch_q)
  ) else $error("latch changed without a strobe");

  // strobe high copies the register into the latch
  load_pass_a: assert property ( // R03
    @(posedge i_clk_sys) disable iff (i_sys_rst)
      load_s |=> latch_q == $past(mirror_q)
  ) else $error("latch did not follow while strobe high");

  // with strobe held, the display follows each shift
  sequence strobe_held_s;
    load_s ##1 load_s;
  endsequence

  property follow_p;
    @(posedge i_clk_sys) disable iff (i_sys_rst)
      strobe_held_s |-> ##1
        ((o_seg ^ {`LSL_SEG_W{o_backplane_drive}})
          == $past(mirror_q, 2));
  endproperty

  two_wire_follow_a: assert property (follow_p) // R04
    else $error("segments do not follow the shift register");

  // segment phase against backplane follows latched bit
  seg_phase_a: assert property ( // R07
    @(posedge i_clk_sys) disable iff (i_sys_rst)
      ##1 ((o_seg ^ {`LSL_SEG_W{o_backplane_drive}})
        == $past(latch_q))
  ) else $error("segment phase does not match latched bit");

  // backplane and segments switch together on a flip
  bp_edge_a: assert property ( // R07
    @(posedge i_clk_sys) disable iff (i_sys_rst)
      $changed(o_backplane_drive) && $stable(latch_q)
        && ($past(latch_q) == $past(latch_q, 2)) |->
        o_seg == ~$past(o_seg)
  ) else $error("segments did not flip with backplane");

  // no pending bit, so the mirror and pointer rest
  mirror_rest_a: assert property ( // R01
    @(posedge i_clk_sys) disable iff (i_sys_rst)
      (rptr_q == wbin_s) |=> $stable(mirror_q) && $stable(rptr_q)
  ) else $error("mirror moved with no pending bit");

  // each pending bit moves the read pointer by one
  rptr_step_a: assert property ( // R01
    @(posedge i_clk_sys) disable iff (i_sys_rst)
      (rptr_q != wbin_s) |=> rptr_q == lsl_ptr_t'($past(rptr_q) + 1'b1)
  ) else $error("read pointer did not step by one");

  // the latch only ever takes a copy of the mirror
  latch_src_a: assert property ( // R02
    @(posedge i_clk_sys) disable iff (i_sys_rst)
      $changed(latch_q) |-> $past(load_s) && (latch_q == $past(mirror_q))
  ) else $error("latch changed to a value not from the mirror");

  // reset gives a blank display and a low backplane
  seg_rst_a: assert property ( // R07
    @(posedge i_clk_sys)
      i_sys_rst |=> (o_seg == '0)
  ) else $error("segments not cleared by reset");

  bp_rst_a: assert property ( // R07
    @(posedge i_clk_sys)
      i_sys_rst |=> !o_backplane_drive
  ) else $error("backplane not low after reset");

endmodule : lsl_shift_latch

`default_nettype wire

/* test/lsl_host_model.sv */
// Purpose: host model for the serial link of the segment driver.
// Assumes: 30 ns link period; link clock idles low outside frames.
// Notes:   the bench calls the tasks below.
`default_nettype none
module lsl_host_model (
  // serial link toward the driver
  output var logic o_shift_clk,
  output var logic o_ser_data,
  output var logic o_load
);
  timeunit 1ns;
  timeprecision 100ps;
  // idle levels at time zero
  initial begin
    o_shift_clk = 1'b0;
    o_ser_data  = 1'b0;
    o_load      = 1'b0;
  end
  // one bit per link period, clock still once the call ends
  task automatic shift_bit(input logic d);
    o_ser_data = d;
    #13.7 o_shift_clk = 1'b1;
    #8.0 o_ser_data = ~d;  // held past the rise, then the inverse
    #7.0 o_shift_clk = 1'b0;
    #1.3;
  endtask : shift_bit
  // level strobe, held high for two-wire use
  task automatic set_load(input logic v);
    o_load = v;
  endtask : set_load
endmodule : lsl_host_model
`default_nettype wire

/* test/lsl_shift_latch_tb_top.sv */
// Purpose: self-checking bench of the segment shift latch.
// Assumes: host model drives the link at 30 ns per bit.
// Notes:   short backplane half period keeps the run brief.
`default_nettype none
module lsl_shift_latch_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import lsl_pkg::*;
  localparam int unsigned HALF = 16;
  logic     clk_sys;
  logic     sys_rst;
  logic     shift_clk;
  logic     ser_data;
  logic     load;
  logic     cascade;
  logic     bp;
  logic     b0;
  lsl_seg_t seg;
  lsl_seg_t exp_sr;
  lsl_seg_t held;
  lsl_seg_t frame;
  int       err_count;
  int       checks_done;
  int       seed;
  int       n;
  // device and its host
  lsl_shift_latch #(.BP_HALF_CYC(HALF)) u_lsl_shift_latch (
    .i_clk_sys(clk_sys), .i_sys_rst(sys_rst),
    .i_shift_clk(shift_clk), .i_ser_data(ser_data), .i_load(load),
    .o_cascade_out(cascade), .o_backplane_drive(bp), .o_seg(seg)
  );
  lsl_host_model u_lsl_host_model (
    .o_shift_clk(shift_clk), .o_ser_data(ser_data), .o_load(load)
  );
  // system clock
  initial clk_sys = 1'b0;
  always #4 clk_sys = ~clk_sys;
  // compare and count
  task automatic check(input string nm, input logic [30:0] e, g);
    checks_done++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : check
  // verdict and end of run
  task automatic conclude();
    if (err_count == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : conclude
  // settle just after a system edge
  task automatic sys_wait(input int k);
    repeat (k) @(posedge clk_sys);
    #1;
  endtask : sys_wait
  // segment drive expected from latched bits and backplane
  function automatic lsl_seg_t drive_of(lsl_seg_t l, logic b);
    return l ^ {31{b}};
  endfunction : drive_of
  task automatic seg_chk(input string nm);
    check(nm, drive_of(held, bp), seg);
  endtask : seg_chk
  // one shift with the cascade bit checked
  task automatic shift_chk(input logic d);
    u_lsl_host_model.shift_bit(d);
    exp_sr = {exp_sr[29:0], d};
    check("cascade", 31'(exp_sr[30]), 31'(cascade));
  endtask : shift_chk
  // hang guard
  initial begin
    #200000;
    err_count++;
    conclude();
  end
  // main sequence
  initial begin
    err_count = 0;
    checks_done = 0;
    seed = 8926;
    sys_rst = 1'b1;
    exp_sr = '0;
    held = '0;
    repeat (4) u_lsl_host_model.shift_bit(1'b0);  // link edges in reset
    sys_wait(3);
    sys_rst = 1'b0;
    sys_wait(1);
    check("bp_rst", 31'h0, 31'(bp));
    seg_chk("seg_rst");
    repeat (3) shift_chk(1'b0);
    // three-wire frames: hold while shifting, then load
    for (int f = 0; f < 5; f++) begin
      frame = (f == 0) ? 31'h7FFFFFFF : (f == 1) ? 31'h2AAAAAAA
              : 31'($random(seed));
      for (int i = 30; i >= 0; i--) shift_chk(frame[i]);
      sys_wait(10);
      seg_chk("seg_hold");
      u_lsl_host_model.set_load(1'b1);
      held = exp_sr;
      sys_wait(10);
      seg_chk("seg_load");
      u_lsl_host_model.set_load(1'b0);
      sys_wait(4);
    end
    // backplane half period and segment inversion
    for (int t = 0; t < 3; t++) begin
      n = 0;
      b0 = bp;
      do begin
        sys_wait(1);
        n++;
      end while (bp === b0 && n < 64);
      if (n >= 64) begin
        err_count++;
        conclude();
      end
      if (t > 0) check("bp_half", 31'(HALF), 31'(n));
      seg_chk("seg_flip");
    end
    // two-wire: segments follow every shift
    u_lsl_host_model.set_load(1'b1);
    for (int i = 0; i < 31; i++) begin
      shift_chk(1'($random(seed)));
      held = exp_sr;
      sys_wait(8);
      seg_chk("seg_walk");
    end
    conclude();
  end
endmodule : lsl_shift_latch_tb_top
`default_nettype wire
